// ---- core/rtw_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtw_regs.svh"

// ----------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------
module rtw_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = `RTW_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != DEPTH[AW:0];
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 1'b1;
        2'b01:   cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule : rtw_fifo

// ----------------------------------------------------------------
// device end of the two-wire port
// ----------------------------------------------------------------
module rtw_slave (
  // clock and reset
  input  wire logic   clock,
  input  wire logic   reset,
  // serial bus
  rtw_if.slave        bus,
  // supply status, asynchronous
  input  wire logic   on_backup,
  // read port of the memory
  output logic [6:0]  rd_addr,
  input  wire logic [7:0] rd_data,
  // written bytes
  output logic        wr_valid,
  input  wire logic   wr_ready,
  output logic [6:0]  wr_addr,
  output logic [7:0]  wr_data
);
  rtw_pkg::rtw_slv_e  state_q;
  rtw_pkg::rtw_kind_e kind_q;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic [6:0] ptr_q;
  logic       rw_q;
  logic       ack_q;
  logic       mack_q;
  logic       sda_low_q;
  logic       scl_m_q, scl_s_q, scl_p_q;
  logic       sda_m_q, sda_s_q, sda_p_q;
  logic       bkp_m_q, bkp_s_q;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic       rx_end, ack_end, tx_next, tx_end, mack_end, load_rd;
  logic       give_ack, addr_ok, fifo_ready, push;
  logic [6:0] ptr_inc;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {bkp_m_q, bkp_s_q}          <= 2'h0;
    end
    else
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= {bus.scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {bus.sda, sda_m_q, sda_s_q};
      {bkp_m_q, bkp_s_q}          <= {on_backup, bkp_m_q};
    end
  end

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------------------------------
  // byte events and decisions
  // ----------------------------------------------------------------
  assign rx_end   = (state_q == rtw_pkg::ST_RX) & scl_fall & (cnt_q == 4'h8);
  assign ack_end  = (state_q == rtw_pkg::ST_ACK) & scl_fall;
  assign tx_next  = (state_q == rtw_pkg::ST_TX) & scl_fall & (cnt_q != 4'h8);
  assign tx_end   = (state_q == rtw_pkg::ST_TX) & scl_fall & (cnt_q == 4'h8);
  assign mack_end = (state_q == rtw_pkg::ST_TXACK) & scl_fall & mack_q;
  assign load_rd  = (ack_end & ack_q & rw_q & (kind_q == rtw_pkg::KD_CTRL)) | mack_end;
  assign addr_ok  = shreg_q < `RTW_LOC_END;
  assign ptr_inc  = (ptr_q == `RTW_LOC_LAST) ? 7'h00 : ptr_q + 7'h01;

  always_comb
  begin
    case (kind_q)
      rtw_pkg::KD_CTRL: give_ack = shreg_q[7:1] == `RTW_SLAVE_ADDR;
      rtw_pkg::KD_ADDR: give_ack = addr_ok;
      // full buffer refuses the byte by withholding acknowledge
      default:          give_ack = fifo_ready;
    endcase
  end

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= rtw_pkg::ST_IDLE;
      kind_q  <= rtw_pkg::KD_CTRL;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      mack_q  <= 1'b0;
    end
    else if (bkp_s_q)
    begin
      state_q <= rtw_pkg::ST_IDLE;
    end
    else if (start_det)
    begin
      state_q <= rtw_pkg::ST_RX;
      kind_q  <= rtw_pkg::KD_CTRL;
      cnt_q   <= 4'h0;
    end
    else if (stop_det)
    begin
      state_q <= rtw_pkg::ST_IDLE;
    end
    else
    begin
      case (state_q)
        rtw_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 4'h1;
          end
          else if (rx_end)
          begin
            if (kind_q == rtw_pkg::KD_CTRL && !give_ack)
            begin
              state_q <= rtw_pkg::ST_IGNORE;
            end
            else
            begin
              state_q <= rtw_pkg::ST_ACK;
              ack_q   <= give_ack;
            end
            if (kind_q == rtw_pkg::KD_CTRL)
            begin
              rw_q <= shreg_q[0];
            end
          end
        end
        rtw_pkg::ST_ACK:
        begin
          if (ack_end)
          begin
            cnt_q <= 4'h0;
            if (!ack_q)
            begin
              state_q <= rtw_pkg::ST_IGNORE;
            end
            else if (load_rd)
            begin
              state_q <= rtw_pkg::ST_TX;
            end
            else
            begin
              state_q <= rtw_pkg::ST_RX;
              kind_q  <= (kind_q == rtw_pkg::KD_CTRL) ? rtw_pkg::KD_ADDR : rtw_pkg::KD_DATA;
            end
          end
        end
        rtw_pkg::ST_TX:
        begin
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 4'h1;
          end
          else if (tx_end)
          begin
            state_q <= rtw_pkg::ST_TXACK;
          end
        end
        rtw_pkg::ST_TXACK:
        begin
          if (scl_rise)
          begin
            mack_q <= ~sda_s_q;
          end
          else if (scl_fall)
          begin
            cnt_q   <= 4'h0;
            state_q <= mack_q ? rtw_pkg::ST_TX : rtw_pkg::ST_IGNORE;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift register and location pointer
  // ----------------------------------------------------------------
  assign push = rx_end & (kind_q == rtw_pkg::KD_DATA) & fifo_ready;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      shreg_q <= 8'h00;
      ptr_q   <= 7'h00;
    end
    else
    begin
      if (scl_rise && state_q == rtw_pkg::ST_RX)
      begin
        shreg_q <= {shreg_q[6:0], sda_s_q};
      end
      else if (load_rd)
      begin
        shreg_q <= rd_data;
      end
      else if (tx_next)
      begin
        shreg_q <= {shreg_q[6:0], 1'b0};
      end
      if (rx_end && kind_q == rtw_pkg::KD_ADDR && addr_ok)
      begin
        ptr_q <= shreg_q[6:0];
      end
      else if (push || load_rd)
      begin
        ptr_q <= ptr_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // sda driver
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sda_low_q <= 1'b0;
    end
    else if (bkp_s_q || start_det || stop_det)
    begin
      sda_low_q <= 1'b0;
    end
    else if (rx_end)
    begin
      sda_low_q <= give_ack;
    end
    else if (load_rd)
    begin
      sda_low_q <= ~rd_data[7];
    end
    else if (tx_next)
    begin
      sda_low_q <= ~shreg_q[6];
    end
    else if (ack_end || tx_end || (state_q == rtw_pkg::ST_TXACK && scl_fall))
    begin
      sda_low_q <= 1'b0;
    end
  end

  assign bus.s_sda_o    = 1'b0;
  assign bus.s_sda_oe_n = ~sda_low_q;
  assign rd_addr        = ptr_q;

  rtw_fifo #(.WIDTH(15), .DEPTH(`RTW_FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({ptr_q, shreg_q}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );
endmodule : rtw_slave

`default_nettype wire

// ---- core/rtw_regs.svh ----
`ifndef RTW_REGS_SVH
`define RTW_REGS_SVH

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
`define RTW_SLAVE_ADDR     7'h6f
`define RTW_LOC_END        8'h60
`define RTW_LOC_LAST       7'h5f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTW_CLK_PERIOD_NS  5
`define RTW_SCL_PERIOD_NS  2500
`define RTW_QTR_CYCLES     (`RTW_SCL_PERIOD_NS / (4 * `RTW_CLK_PERIOD_NS))

// ----------------------------------------------------------------
// buffering
// ----------------------------------------------------------------
`define RTW_FIFO_DEPTH     32

`endif

// ---- core/rtw_pkg.sv ----
`default_nettype none
package rtw_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_IGNORE} rtw_slv_e;
  typedef enum logic [1:0] {KD_CTRL, KD_ADDR, KD_DATA} rtw_kind_e;
  typedef enum logic [1:0] {M_IDLE, M_COND, M_WAIT, M_BIT} rtw_mst_e;
  typedef enum logic [1:0] {C_START, C_RSTART, C_STOP} rtw_cond_e;
  typedef enum logic [2:0] {SG_CTRLW, SG_REG, SG_WDATA, SG_CTRLR, SG_RDATA} rtw_stage_e;

endpackage : rtw_pkg

`default_nettype wire

// ---- core/rtw_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// open-drain wires: a line is low when any enable is low
interface rtw_if;
  logic scl_o;
  logic scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  assign scl = scl_oe_n | scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

  modport master (output scl_o, output scl_oe_n, output m_sda_o, output m_sda_oe_n,
                  input scl, input sda);
  modport slave  (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface : rtw_if

`default_nettype wire

// ---- core/rtw_master.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtw_regs.svh"

// ----------------------------------------------------------------
// bus master end: makes scl by dividing the system clock
// ----------------------------------------------------------------
module rtw_master #(
  parameter int QTR = `RTW_QTR_CYCLES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // serial bus
  rtw_if.master           bus,
  // command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_count,
  // write data stream
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // read data and status
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            done,
  output logic            nack
);
  rtw_pkg::rtw_mst_e   state_q;
  rtw_pkg::rtw_cond_e  cond_q;
  rtw_pkg::rtw_stage_e stage_q;
  logic [15:0] div_q;
  logic        tick;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [7:0]  shreg_q;
  logic [7:0]  left_q;
  logic [7:0]  reg_q;
  logic        read_q;
  logic        bad_q;
  logic        scl_low_q;
  logic        sda_low_q;
  logic        sda_m_q, sda_s_q, scl_m_q, scl_s_q;
  logic        is_rx;
  logic [7:0]  left_dec;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      {sda_m_q, sda_s_q, scl_m_q, scl_s_q} <= 4'hf;
      div_q <= 16'h0000;
    end
    else
    begin
      {sda_m_q, sda_s_q} <= {bus.sda, sda_m_q};
      {scl_m_q, scl_s_q} <= {bus.scl, scl_m_q};
      div_q <= (div_q == 16'(QTR - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  assign tick      = div_q == 16'(QTR - 1);
  assign is_rx     = stage_q == rtw_pkg::SG_RDATA;
  assign left_dec  = left_q - 8'h01;
  assign cmd_ready = (state_q == rtw_pkg::M_IDLE) & sda_s_q & scl_s_q;
  assign tx_ready  = state_q == rtw_pkg::M_WAIT;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q   <= rtw_pkg::M_IDLE;
      cond_q    <= rtw_pkg::C_START;
      stage_q   <= rtw_pkg::SG_CTRLW;
      ph_q      <= 2'h0;
      bit_q     <= 4'h0;
      shreg_q   <= 8'h00;
      left_q    <= 8'h00;
      reg_q     <= 8'h00;
      read_q    <= 1'b0;
      bad_q     <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      rx_valid  <= 1'b0;
      rx_data   <= 8'h00;
      done      <= 1'b0;
      nack      <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      done     <= 1'b0;
      case (state_q)
        rtw_pkg::M_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            read_q  <= cmd_read;
            reg_q   <= cmd_reg;
            left_q  <= (cmd_read && cmd_count == 8'h00) ? 8'h01 : cmd_count;
            nack    <= 1'b0;
            state_q <= rtw_pkg::M_COND;
            cond_q  <= rtw_pkg::C_START;
            ph_q    <= 2'h0;
          end
        end
        rtw_pkg::M_COND:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case ({cond_q, ph_q})
              {rtw_pkg::C_START, 2'h1}:  sda_low_q <= 1'b1;
              {rtw_pkg::C_START, 2'h2}:
              begin
                scl_low_q <= 1'b1;
                state_q   <= rtw_pkg::M_BIT;
                stage_q   <= rtw_pkg::SG_CTRLW;
                shreg_q   <= {`RTW_SLAVE_ADDR, 1'b0};
                ph_q      <= 2'h0;
                bit_q     <= 4'h0;
              end
              {rtw_pkg::C_RSTART, 2'h0}: sda_low_q <= 1'b0;
              {rtw_pkg::C_RSTART, 2'h1}: scl_low_q <= 1'b0;
              {rtw_pkg::C_RSTART, 2'h2}: sda_low_q <= 1'b1;
              {rtw_pkg::C_RSTART, 2'h3}:
              begin
                scl_low_q <= 1'b1;
                state_q   <= rtw_pkg::M_BIT;
                stage_q   <= rtw_pkg::SG_CTRLR;
                shreg_q   <= {`RTW_SLAVE_ADDR, 1'b1};
                bit_q     <= 4'h0;
              end
              {rtw_pkg::C_STOP, 2'h0}:   sda_low_q <= 1'b1;
              {rtw_pkg::C_STOP, 2'h1}:   scl_low_q <= 1'b0;
              {rtw_pkg::C_STOP, 2'h2}:
              begin
                sda_low_q <= 1'b0;
                state_q   <= rtw_pkg::M_IDLE;
                done      <= 1'b1;
              end
              default: ph_q <= ph_q + 2'h1;
            endcase
          end
        end
        rtw_pkg::M_WAIT:
        begin
          if (tx_valid)
          begin
            shreg_q <= tx_data;
            state_q <= rtw_pkg::M_BIT;
            ph_q    <= 2'h0;
            bit_q   <= 4'h0;
          end
        end
        rtw_pkg::M_BIT:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0:
              begin
                if (bit_q != 4'h8)
                begin
                  sda_low_q <= ~is_rx & ~shreg_q[7];
                end
                else
                begin
                  sda_low_q <= is_rx & (left_q != 8'h01);
                end
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2:
              begin
                if (bit_q != 4'h8 && is_rx)
                begin
                  shreg_q <= {shreg_q[6:0], sda_s_q};
                end
                bad_q <= sda_s_q;
              end
              default:
              begin
                scl_low_q <= 1'b1;
                if (bit_q != 4'h8)
                begin
                  bit_q <= bit_q + 4'h1;
                  if (!is_rx)
                  begin
                    shreg_q <= {shreg_q[6:0], 1'b0};
                  end
                end
                else
                begin
                  bit_q   <= 4'h0;
                  state_q <= rtw_pkg::M_BIT;
                  if (is_rx)
                  begin
                    rx_valid <= 1'b1;
                    rx_data  <= shreg_q;
                  end
                  if (!is_rx && bad_q)
                  begin
                    nack    <= 1'b1;
                    state_q <= rtw_pkg::M_COND;
                    cond_q  <= rtw_pkg::C_STOP;
                  end
                  else
                  begin
                    case (stage_q)
                      rtw_pkg::SG_CTRLW:
                      begin
                        stage_q <= rtw_pkg::SG_REG;
                        shreg_q <= reg_q;
                      end
                      rtw_pkg::SG_REG:
                      begin
                        stage_q <= rtw_pkg::SG_WDATA;
                        state_q <= read_q ? rtw_pkg::M_COND
                                 : (left_q == 8'h00) ? rtw_pkg::M_COND : rtw_pkg::M_WAIT;
                        cond_q  <= read_q ? rtw_pkg::C_RSTART : rtw_pkg::C_STOP;
                      end
                      rtw_pkg::SG_CTRLR: stage_q <= rtw_pkg::SG_RDATA;
                      default:
                      begin
                        left_q  <= left_dec;
                        state_q <= (left_dec == 8'h00) ? rtw_pkg::M_COND
                                 : is_rx ? rtw_pkg::M_BIT : rtw_pkg::M_WAIT;
                        cond_q  <= rtw_pkg::C_STOP;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        default: state_q <= rtw_pkg::M_IDLE;
      endcase
    end
  end

  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe_n   = ~scl_low_q;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_sda_oe_n = ~sda_low_q;
endmodule : rtw_master

`default_nettype wire

// ---- sim/rtw_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// line checks
// ----------------------------------------------------------------
module rtw_props (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // resolved lines and device driver
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_od; !s_sda_oe_n |-> !s_sda_o && !sda; endproperty
  a_od: assert property (p_od)
    else $error("device drives sda high");
  property p_dev_edge;
    $changed(s_sda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2);
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("device moved sda outside scl low");
  property p_ack_hold; scl && !s_sda_oe_n |=> !s_sda_oe_n; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device let go of sda during scl high");
  property p_no_cond; scl && $past(scl) && $changed(sda) |-> s_sda_oe_n && $past(s_sda_oe_n);
  endproperty
  a_no_cond: assert property (p_no_cond)
    else $error("device changed sda while scl high");
  property p_scl_hi; $rose(scl) |-> scl [*4]; endproperty
  a_scl_hi: assert property (p_scl_hi)
    else $error("scl high phase too short");
  property p_scl_lo; $fell(scl) |-> !scl [*4]; endproperty
  a_scl_lo: assert property (p_scl_lo)
    else $error("scl low phase too short");
  property p_start; scl && $fell(sda) |-> scl [*2]; endproperty
  a_start: assert property (p_start)
    else $error("start not held");
  property p_stop; scl && $rose(sda) |-> (scl && sda) [*4]; endproperty
  a_stop: assert property (p_stop)
    else $error("bus not idle after stop");

  c_ack: cover property ($fell(s_sda_oe_n));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule : rtw_props
`default_nettype wire

// ---- sim/rtcc_two_wire_slave_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtcc_two_wire_slave_port_test;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        on_backup = 1'b0;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        wr_valid;
  logic        wr_ready = 1'b0;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready;
  logic        cmd_read = 1'b0;
  logic [7:0]  cmd_reg = 8'h00;
  logic [7:0]  cmd_count = 8'h00;
  logic        tx_ready;
  logic [7:0]  tx_data = 8'h00;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        done;
  logic        nack;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [15:0] wq[$];
  logic [7:0]  rq[$];

  always #2.5 clock = ~clock;
  // memory stand-in, answers in the same cycle
  assign rd_data = {1'b1, rd_addr} ^ 8'h3c;

  rtw_if lnk ();
  rtw_master #(.QTR(8)) i_rtw_master (.clock, .reset, .bus(lnk.master), .cmd_valid,
    .cmd_ready, .cmd_read, .cmd_reg, .cmd_count, .tx_valid(1'b1), .tx_ready, .tx_data,
    .rx_valid, .rx_data, .done, .nack);
  rtw_slave i_rtw_slave (.clock, .reset, .bus(lnk.slave), .on_backup, .rd_addr, .rd_data,
    .wr_valid, .wr_ready, .wr_addr, .wr_data);
  rtw_props i_rtw_props (.clock, .reset, .scl(lnk.scl), .sda(lnk.sda),
    .s_sda_o(lnk.s_sda_o), .s_sda_oe_n(lnk.s_sda_oe_n));

  // ----------------------------------------------------------------
  // user-side traffic and watchdog
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (tx_ready === 1'b1)
      tx_data <= tx_data + 8'h01;
    if (rx_valid === 1'b1)
      rq.push_back(rx_data);
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back({1'b0, wr_addr, wr_data});
    if (cycles == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // hangs are cut by the watchdog, so the waits carry no own bound
  task automatic run(input logic rd, input logic [7:0] rg, input logic [7:0] cnt);
    @(negedge clock);
    while (cmd_ready !== 1'b1)
      @(negedge clock);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= rg;
    cmd_count <= cnt;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // done stands one cycle: looked at mid-cycle, not at its launching edge
    do
      @(negedge clock);
    while (done !== 1'b1);
    @(posedge clock);
  endtask : run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_fill();
    run(1'b0, 8'h00, 8'd33);
    check(nack, 1'b1);
    check(16'(wq.size()), 16'd0);
    wr_ready <= 1'b1;
    @(posedge clock);
    while (wr_valid === 1'b1)
      @(posedge clock);
    check(16'(wq.size()), 16'd32);
    foreach (wq[i])
      check(wq[i], {1'b0, i[6:0], i[7:0]});
  endtask : t_fill

  task automatic t_read();
    run(1'b1, 8'h5f, 8'd2);
    check(nack, 1'b0);
    check(16'(rq.size()), 16'd2);
    check(rq[0], 8'he3);
    check(rq[1], 8'hbc);
    check(lnk.s_sda_oe_n, 1'b1);
  endtask : t_read

  task automatic t_range();
    run(1'b0, 8'h5f, 8'd0);
    check(nack, 1'b0);
    run(1'b0, 8'h60, 8'd0);
    check(nack, 1'b1);
  endtask : t_range

  task automatic t_backup();
    wq.delete();
    on_backup <= 1'b1;
    run(1'b0, 8'h10, 8'd1);
    check(nack, 1'b1);
    check(16'(wq.size()), 16'd0);
    on_backup <= 1'b0;
  endtask : t_backup

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    t_fill();
    t_read();
    t_range();
    t_backup();
    tally_and_finish();
  end
endmodule : rtcc_two_wire_slave_port_test
`default_nettype wire
